// ### rtl/mioc_pkg.sv
// Constants and types shared by the Modbus digital I/O counter slave.
package mioc_pkg;
    // ==========================================================
    // Sizes and register map
    localparam int NUM_IN = 8;
    localparam int NUM_RLY = 4;
    localparam logic [15:0] IN_COUNT = 16'h0008;
    localparam logic [15:0] RLY_COUNT = 16'h0004;
    localparam logic [15:0] REG_COUNT = 16'h0028;
    localparam logic [5:0] WIDE_BASE = 6'h18;
    localparam logic [5:0] REG_PER_IN = 6'h03;
    localparam logic [3:0] BUF_LEN = 4'hA;
    localparam logic [3:0] REQ_LEN = 4'h8;
    localparam logic [3:0] MULTI_LEN = 4'hA;
    localparam logic [6:0] HDR_LEN = 7'h03;
    localparam logic [6:0] BITS_LEN = 7'h04;
    localparam logic [6:0] ECHO_LEN = 7'h06;
    localparam logic [6:0] EXC_LEN = 7'h03;
    localparam logic [31:0] CNT_RESET = 32'h0000_0000;
    localparam logic [3:0] RLY_RESET = 4'h0;
    // ==========================================================
    // Protocol codes
    localparam logic [7:0] FC_RD_COILS = 8'h01;
    localparam logic [7:0] FC_RD_INPUTS = 8'h02;
    localparam logic [7:0] FC_RD_HOLD = 8'h03;
    localparam logic [7:0] FC_RD_INREG = 8'h04;
    localparam logic [7:0] FC_WR_COIL = 8'h05;
    localparam logic [7:0] FC_WR_REG = 8'h06;
    localparam logic [7:0] FC_WR_MULTI = 8'h0F;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_VAL = 8'h03;
    localparam logic [7:0] BCAST = 8'h00;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic [15:0] COIL_ON = 16'hFF00;
    localparam logic [15:0] COIL_OFF = 16'h0000;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_GOOD = 16'h0000;
    // ==========================================================
    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int ON_UNIT_S = 1;
    localparam int SEC_CYCLES = ON_UNIT_S * CLK_HZ;
    // ==========================================================
    // Types
    typedef enum logic [2:0] {ST_RX = 3'b001, ST_EXEC = 3'b010, ST_TX = 3'b100} mioc_state_t;
    typedef enum logic [1:0] {RK_REGS = 2'h0, RK_BITS = 2'h1, RK_ECHO = 2'h2, RK_EXC = 2'h3} mioc_kind_t;
endpackage

// ### rtl/mioc_slave.sv
// Modbus RTU slave core: input filters, pulse and on-time counters, relays and frame handling.
`timescale 1ns/1ps
module mioc_slave
    import mioc_pkg::*;
#(
    parameter int SEC_CYC = SEC_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Received bytes
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_frame_end,
    // Transmitted bytes
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    // Configuration
    input wire logic [7:0] station_addr,
    input wire logic [7:0] invert_mask,
    input wire logic [23:0] filter_cycles,
    // Pins
    input wire logic [7:0] din,
    output logic [3:0] relay
);
    // ==========================================================
    // State
    logic [7:0] din_meta, din_sync, raw, filt, next_filt;
    logic [23:0] fcnt [NUM_IN];
    logic [23:0] next_fcnt [NUM_IN];
    logic [31:0] pulse [NUM_IN];
    logic [31:0] next_pulse [NUM_IN];
    logic [31:0] ontime [NUM_IN];
    logic [31:0] next_ontime [NUM_IN];
    logic [31:0] subsec [NUM_IN];
    logic [31:0] next_subsec [NUM_IN];
    logic [7:0] rbuf [BUF_LEN];
    logic [7:0] next_rbuf [BUF_LEN];
    mioc_state_t state, next_state;
    mioc_kind_t kind, next_kind;
    logic [3:0] rx_len, next_rx_len, next_relay;
    logic rx_ovf, next_rx_ovf, reg_wr;
    logic [15:0] rx_crc, next_rx_crc, tx_crc, next_tx_crc;
    logic [6:0] tx_idx, next_tx_idx, tx_len, next_tx_len;
    logic [7:0] exc_code, next_exc_code, next_tx_data, fc;
    logic [15:0] st, qty, val;
    logic [16:0] stop;

    assign fc = rbuf[1];
    assign st = {rbuf[2], rbuf[3]};
    assign qty = {rbuf[4], rbuf[5]};
    assign val = qty;
    assign stop = {1'b0, st} + {1'b0, qty};
    assign raw = din_sync ^ invert_mask;
    assign tx_valid = (state == ST_TX);
    assign tx_last = tx_valid && (tx_idx == tx_len + 7'h01);

    // ==========================================================
    // Helpers
    function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // Returns input number and field: 0 pulse lo, 1 pulse hi, 2 on-time lo, 3 on-time hi.
    function automatic logic [4:0] reg_map(input logic [5:0] idx);
        logic [5:0] n;
        logic [5:0] r;
        if (idx < WIDE_BASE) begin
            n = idx / REG_PER_IN;
            r = idx - n * REG_PER_IN;
            return {n[2:0], (r == 6'h00) ? 2'h0 : ((r == 6'h01) ? 2'h2 : 2'h3)};
        end
        n = (idx - WIDE_BASE) >> 1;
        return {n[2:0], 1'b0, idx[0]};
    endfunction

    function automatic logic [15:0] reg_word(input logic [5:0] idx);
        logic [4:0] m;
        logic [31:0] v;
        m = reg_map(idx);
        v = m[1] ? ontime[m[4:2]] : pulse[m[4:2]];
        return m[0] ? v[31:16] : v[15:0];
    endfunction

    function automatic logic [7:0] tx_byte(input logic [6:0] k, input logic [15:0] c);
        logic [6:0] off;
        logic [15:0] w;
        logic [7:0] bits;
        off = k - HDR_LEN;
        w = reg_word(6'(st[5:0] + {1'b0, off[6:1]}));
        bits = ((fc == FC_RD_COILS) ? {4'h0, relay} : filt) >> st[2:0];
        bits = bits & 8'((9'h001 << qty[3:0]) - 9'h001);
        if (k == tx_len) begin
            return c[7:0];
        end else if (k > tx_len) begin
            return c[15:8];
        end else if (k == 7'h00) begin
            return rbuf[0];
        end else if (k == 7'h01) begin
            return (kind == RK_EXC) ? (fc | EXC_FLAG) : fc;
        end
        case (kind)
            RK_REGS: return (k == 7'h02) ? qty[6:0] << 1 : (off[0] ? w[7:0] : w[15:8]);
            RK_BITS: return (k == 7'h02) ? ONE_BYTE : bits;
            RK_ECHO: return rbuf[k[3:0]];
            default: return exc_code;
        endcase
    endfunction

    // ==========================================================
    // Input filter and counters
    always_comb begin
        logic [4:0] m;
        m = reg_map(st[5:0]);
        next_filt = filt;
        next_fcnt = fcnt;
        next_pulse = pulse;
        next_ontime = ontime;
        next_subsec = subsec;
        for (int i = 0; i < NUM_IN; i++) begin
            if (raw[i] != filt[i]) begin
                if (fcnt[i] >= filter_cycles) begin
                    next_filt[i] = raw[i];
                    next_fcnt[i] = '0;
                    if (raw[i]) begin
                        next_pulse[i] = pulse[i] + 32'h1;
                    end
                end else begin
                    next_fcnt[i] = fcnt[i] + 24'h1;
                end
            end else begin
                next_fcnt[i] = '0;
            end
            if (filt[i]) begin
                if (subsec[i] >= 32'(SEC_CYC - 1)) begin
                    next_subsec[i] = '0;
                    next_ontime[i] = ontime[i] + 32'h1;
                end else begin
                    next_subsec[i] = subsec[i] + 32'h1;
                end
            end
        end
        if (reg_wr) begin
            case (m[1:0])
                2'h0: next_pulse[m[4:2]][15:0] = val;
                2'h1: next_pulse[m[4:2]][31:16] = val;
                2'h2: next_ontime[m[4:2]][15:0] = val;
                default: next_ontime[m[4:2]][31:16] = val;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            din_meta <= 8'h00;
            din_sync <= 8'h00;
            filt <= 8'h00;
            for (int i = 0; i < NUM_IN; i++) begin
                fcnt[i] <= '0;
                pulse[i] <= CNT_RESET;
                ontime[i] <= CNT_RESET;
                subsec[i] <= CNT_RESET;
            end
        end else begin
            din_meta <= din;
            din_sync <= din_meta;
            filt <= next_filt;
            fcnt <= next_fcnt;
            pulse <= next_pulse;
            ontime <= next_ontime;
            subsec <= next_subsec;
        end
    end

    // ==========================================================
    // Frame handling
    always_comb begin
        logic [15:0] lim;
        next_state = state;
        next_kind = kind;
        next_rbuf = rbuf;
        next_rx_len = rx_len;
        next_rx_ovf = rx_ovf;
        next_rx_crc = rx_crc;
        next_relay = relay;
        next_exc_code = exc_code;
        next_tx_idx = tx_idx;
        next_tx_len = tx_len;
        next_tx_crc = tx_crc;
        next_tx_data = tx_data;
        reg_wr = 1'b0;
        lim = RLY_COUNT;
        case (state)
            ST_RX: begin
                if (rx_valid) begin
                    if (rx_len < BUF_LEN) begin
                        next_rbuf[rx_len] = rx_data;
                        next_rx_len = rx_len + 4'h1;
                        next_rx_crc = crc16(rx_crc, rx_data);
                    end else begin
                        next_rx_ovf = 1'b1;
                    end
                end
                if (rx_frame_end && rx_len != 4'h0) begin
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                next_state = ST_RX;
                next_rx_len = 4'h0;
                next_rx_ovf = 1'b0;
                next_rx_crc = CRC_INIT;
                if (!rx_ovf && rx_crc == CRC_GOOD && (rbuf[0] == station_addr || rbuf[0] == BCAST)
                        && rx_len == ((fc == FC_WR_MULTI) ? MULTI_LEN : REQ_LEN)) begin
                    next_kind = RK_EXC;
                    next_exc_code = EXC_FUNC;
                    next_tx_len = EXC_LEN;
                    case (fc)
                        FC_RD_COILS, FC_RD_INPUTS: begin
                            lim = (fc == FC_RD_COILS) ? RLY_COUNT : IN_COUNT;
                            if (qty == 16'h0 || qty > lim) begin
                                next_exc_code = EXC_VAL;
                            end else if (stop > {1'b0, lim}) begin
                                next_exc_code = EXC_ADDR;
                            end else begin
                                next_kind = RK_BITS;
                                next_tx_len = BITS_LEN;
                            end
                        end
                        FC_RD_HOLD, FC_RD_INREG: begin
                            if (qty == 16'h0 || qty > REG_COUNT) begin
                                next_exc_code = EXC_VAL;
                            end else if (stop > {1'b0, REG_COUNT}) begin
                                next_exc_code = EXC_ADDR;
                            end else begin
                                next_kind = RK_REGS;
                                next_tx_len = HDR_LEN + {qty[5:0], 1'b0};
                            end
                        end
                        FC_WR_COIL: begin
                            if (st >= RLY_COUNT) begin
                                next_exc_code = EXC_ADDR;
                            end else if (val != COIL_ON && val != COIL_OFF) begin
                                next_exc_code = EXC_VAL;
                            end else begin
                                next_kind = RK_ECHO;
                                next_tx_len = ECHO_LEN;
                                next_relay[st[1:0]] = (val == COIL_ON);
                            end
                        end
                        FC_WR_REG: begin
                            if (st >= REG_COUNT) begin
                                next_exc_code = EXC_ADDR;
                            end else begin
                                next_kind = RK_ECHO;
                                next_tx_len = ECHO_LEN;
                                reg_wr = 1'b1;
                            end
                        end
                        FC_WR_MULTI: begin
                            if (qty == 16'h0 || qty > RLY_COUNT || rbuf[6] != ONE_BYTE) begin
                                next_exc_code = EXC_VAL;
                            end else if (stop > {1'b0, RLY_COUNT}) begin
                                next_exc_code = EXC_ADDR;
                            end else begin
                                next_kind = RK_ECHO;
                                next_tx_len = ECHO_LEN;
                                for (int i = 0; i < NUM_RLY; i++) begin
                                    if (i >= st && i < stop) begin
                                        next_relay[i] = rbuf[7][i - st];
                                    end
                                end
                            end
                        end
                        default: ;
                    endcase
                    if (rbuf[0] != BCAST) begin
                        next_state = ST_TX;
                        next_tx_idx = 7'h00;
                        next_tx_crc = CRC_INIT;
                        next_tx_data = rbuf[0];
                    end
                end
            end
            ST_TX: begin
                if (tx_ready) begin
                    if (tx_last) begin
                        next_state = ST_RX;
                    end else begin
                        if (tx_idx < tx_len) begin
                            next_tx_crc = crc16(tx_crc, tx_data);
                        end
                        next_tx_idx = tx_idx + 7'h01;
                        next_tx_data = tx_byte(tx_idx + 7'h01, next_tx_crc);
                    end
                end
            end
            default: next_state = ST_RX;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_RX;
            kind <= RK_EXC;
            for (int i = 0; i < BUF_LEN; i++) begin
                rbuf[i] <= 8'h00;
            end
            rx_len <= 4'h0;
            rx_ovf <= 1'b0;
            rx_crc <= CRC_INIT;
            relay <= RLY_RESET;
            exc_code <= 8'h00;
            tx_idx <= 7'h00;
            tx_len <= 7'h00;
            tx_crc <= CRC_INIT;
            tx_data <= 8'h00;
        end else begin
            state <= next_state;
            kind <= next_kind;
            rbuf <= next_rbuf;
            rx_len <= next_rx_len;
            rx_ovf <= next_rx_ovf;
            rx_crc <= next_rx_crc;
            relay <= next_relay;
            exc_code <= next_exc_code;
            tx_idx <= next_tx_idx;
            tx_len <= next_tx_len;
            tx_crc <= next_tx_crc;
            tx_data <= next_tx_data;
        end
    end

    // ==========================================================
    // Checks
    a_filter_pass: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(filt[0]) |-> $past(fcnt[0]) >= $past(filter_cycles) && $past(raw[0]))
        else $error("filtered input rose before the filter time");
    a_pulse_step: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(filt[0]) && !$past(reg_wr) |-> pulse[0] == $past(pulse[0]) + 32'h1)
        else $error("pulse count did not follow a filtered rise");
    a_pulse_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
        !$rose(filt[0]) && !$past(reg_wr) |-> $stable(pulse[0]))
        else $error("pulse count moved without a pulse or a write");
    a_ontime_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
        !$past(filt[1]) && !$past(reg_wr) |-> $stable(ontime[1]))
        else $error("on-time moved while the input was inactive");
    a_relay_cause: assert property (@(posedge sys_clk) disable iff (!resetn)
        !$stable(relay) |-> $past(state) == ST_EXEC && kind == RK_ECHO)
        else $error("relay changed outside an accepted write");
    a_coil_on: assert property (@(posedge sys_clk) disable iff (!resetn)
        state == ST_TX && tx_idx == 7'h00 && kind == RK_ECHO && fc == FC_WR_COIL && val == COIL_ON
        |-> relay[st[1:0]])
        else $error("write single coil on did not close the relay");
    a_read_len: assert property (@(posedge sys_clk) disable iff (!resetn)
        state == ST_TX && kind == RK_REGS |-> tx_len == HDR_LEN + {qty[5:0], 1'b0} && qty <= REG_COUNT)
        else $error("register answer length does not match the quantity");
    a_echo_bytes: assert property (@(posedge sys_clk) disable iff (!resetn)
        state == ST_TX && kind == RK_ECHO && tx_idx < ECHO_LEN |-> tx_data == rbuf[tx_idx[3:0]])
        else $error("write answer is not an echo of the request");
    a_tx_finish: assert property (@(posedge sys_clk) disable iff (!resetn)
        tx_last && tx_ready |=> state == ST_RX ##1 !tx_valid)
        else $error("transmitter did not return to receive after the last byte");
endmodule

// ### test/mioc_master.sv
// Modbus RTU master model that sends request frames and collects the answers.
`timescale 1ns/1ps
module mioc_master
    import mioc_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Request bytes
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_frame_end,
    // Answer bytes
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready
);
    logic slow = 1'b0;
    logic hung = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'hA5;
        rx_frame_end = 1'b0;
        tx_ready = 1'b0;
    end
    // ==========================================================
    // Check word and frame exchange
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = CRC_INIT;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
            end
        end
        return c;
    endfunction
    // Idle data shows the inverse of the last byte so a stale value is never mistaken for a fresh one.
    task automatic xfer(input logic [7:0] req[$], output logic [7:0] rsp[$]);
        logic [15:0] c;
        logic done;
        c = crc16(req);
        req.push_back(c[7:0]);
        req.push_back(c[15:8]);
        rsp = {};
        done = 1'b0;
        foreach (req[i]) begin
            @(posedge sys_clk);
            #1;
            rx_valid = 1'b1;
            rx_data = req[i];
        end
        @(posedge sys_clk);
        #1;
        rx_valid = 1'b0;
        rx_data = ~rx_data;
        @(posedge sys_clk);
        #1;
        rx_frame_end = 1'b1;
        @(posedge sys_clk);
        #1;
        rx_frame_end = 1'b0;
        for (int n = 0; n < 600 && !done; n++) begin
            tx_ready = slow ? n[0] : 1'b1;
            @(negedge sys_clk);
            if (tx_valid === 1'b1 && tx_ready) begin
                rsp.push_back(tx_data);
                done = (tx_last === 1'b1);
            end
            @(posedge sys_clk);
            #1;
        end
        tx_ready = 1'b0;
        hung = !done;
    endtask
endmodule

// ### test/mioc_slave_tb.sv
// Self-checking testbench for the Modbus digital I/O counter slave.
`timescale 1ns/1ps
module mioc_slave_tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic rx_valid, rx_frame_end, tx_valid, tx_last, tx_ready;
    logic [7:0] rx_data, tx_data;
    logic [7:0] invert_mask = 8'h00;
    logic [7:0] din = 8'h00;
    logic [23:0] filter_cycles = 24'h000003;
    logic [3:0] relay;
    int miscompares = 0;
    int cmp_count = 0;
    always #5 sys_clk = ~sys_clk;
    mioc_slave #(.SEC_CYC(20)) u_mioc_slave (.sys_clk(sys_clk), .resetn(resetn), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_frame_end(rx_frame_end), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_ready(tx_ready), .station_addr(8'h01), .invert_mask(invert_mask),
        .filter_cycles(filter_cycles), .din(din), .relay(relay));
    mioc_master u_mioc_master (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_frame_end(rx_frame_end), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready));
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // An empty expectation skips the byte comparison and leaves the answer to the caller.
    task automatic run(input logic [7:0] req[$], input logic [7:0] exp[$], output logic [7:0] rsp[$]);
        logic [15:0] c;
        u_mioc_master.xfer(req, rsp);
        if (u_mioc_master.hung) begin
            miscompares++;
            $display("Error at %0t ns: no answer", $time);
            give_verdict();
        end else if (exp.size() > 0) begin
            c = u_mioc_master.crc16(exp);
            exp.push_back(c[7:0]);
            exp.push_back(c[15:8]);
            check(rsp.size(), exp.size());
            foreach (exp[i]) check(rsp[i], exp[i]);
        end
    endtask
    task automatic hold(input int idx, input int hi, input int lo);
        @(posedge sys_clk);
        #1;
        din[idx] = 1'b1;
        repeat (hi) @(posedge sys_clk);
        #1;
        din[idx] = 1'b0;
        repeat (lo) @(posedge sys_clk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_coils();
        logic [7:0] r[$];
        check(u_mioc_master.crc16('{8'h01, 8'h05, 8'h00, 8'h02, 8'hFF, 8'h00}), 32'hFA2D);
        run('{8'h01, 8'h05, 8'h00, 8'h02, 8'hFF, 8'h00}, '{8'h01, 8'h05, 8'h00, 8'h02, 8'hFF, 8'h00}, r);
        check(relay, 4'h4);
        run('{8'h01, 8'h05, 8'h00, 8'h02, 8'h00, 8'h00}, '{8'h01, 8'h05, 8'h00, 8'h02, 8'h00, 8'h00}, r);
        check(relay, 4'h0);
        run('{8'h01, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h0A},
            '{8'h01, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h04}, r);
        check(relay, 4'hA);
        run('{8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h04}, '{8'h01, 8'h01, 8'h01, 8'h0A}, r);
    endtask
    task automatic t_pulses();
        logic [7:0] r[$];
        u_mioc_master.slow = 1'b1;
        repeat (3) hold(0, 10, 10);
        repeat (2) hold(0, 2, 10);
        run('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h03, 8'h02, 8'h00, 8'h03}, r);
        run('{8'h01, 8'h04, 8'h00, 8'h18, 8'h00, 8'h02},
            '{8'h01, 8'h04, 8'h04, 8'h00, 8'h03, 8'h00, 8'h00}, r);
        // The high word goes first, so the pair shows the new high word with the old low word until the second write.
        run('{8'h01, 8'h06, 8'h00, 8'h19, 8'h00, 8'h01}, '{8'h01, 8'h06, 8'h00, 8'h19, 8'h00, 8'h01}, r);
        run('{8'h01, 8'h06, 8'h00, 8'h18, 8'h00, 8'h07}, '{8'h01, 8'h06, 8'h00, 8'h18, 8'h00, 8'h07}, r);
        run('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h03, 8'h02, 8'h00, 8'h07}, r);
        run('{8'h01, 8'h03, 8'h00, 8'h18, 8'h00, 8'h02},
            '{8'h01, 8'h03, 8'h04, 8'h00, 8'h07, 8'h00, 8'h01}, r);
        // A pulse shorter than a longer filter time must leave count and on-time alone.
        filter_cycles = 24'h00000F;
        hold(0, 10, 20);
        run('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h03},
            '{8'h01, 8'h03, 8'h06, 8'h00, 8'h07, 8'h00, 8'h01, 8'h00, 8'h00}, r);
        filter_cycles = 24'h000003;
        u_mioc_master.slow = 1'b0;
    endtask
    task automatic t_ontime();
        logic [7:0] r[$];
        hold(1, 50, 10);
        run('{8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02},
            '{8'h01, 8'h03, 8'h04, 8'h00, 8'h02, 8'h00, 8'h00}, r);
        run('{8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h28}, '{}, r);
        check(r.size(), 85);
        check(r[2], 8'h50);
        check({r[51], r[52], r[53], r[54]}, 32'h0007_0001);
        check(u_mioc_master.crc16(r), 32'h0000);
    endtask
    task automatic t_bad();
        logic [7:0] r[$];
        run('{8'h01, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h87, 8'h01}, r);
        run('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h29}, '{8'h01, 8'h83, 8'h03}, r);
        run('{8'h01, 8'h03, 8'h00, 8'h01, 8'h00, 8'h28}, '{8'h01, 8'h83, 8'h02}, r);
        run('{8'h01, 8'h05, 8'h00, 8'h04, 8'hFF, 8'h00}, '{8'h01, 8'h85, 8'h02}, r);
        check(relay, 4'hA);
    endtask
    task automatic t_invert();
        logic [7:0] r[$];
        @(posedge sys_clk);
        #1;
        din = 8'hA5;
        invert_mask = 8'h0F;
        repeat (12) @(posedge sys_clk);
        run('{8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h08}, '{8'h01, 8'h02, 8'h01, 8'hAA}, r);
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        t_coils();
        t_pulses();
        t_ontime();
        t_bad();
        t_invert();
        give_verdict();
    end
endmodule
